// [rtl/msdh_port.sv]
/*
 * Board-side request/acknowledge port: presents the relative address,
 * runs the argument bus, the handshake, analog start, identity read,
 * reply driver window and power-on reset pulse.
 * Assumes message fields come from logic on clk; device pins are async.
 */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [R01] relative address is message address minus block start, 8 bits.
// [R02] board drives the 16-line argument bus only during a transfer; a control message answered by analog enable leaves it driven.
// [R03] device should release the argument bus after each transfer.
// [R04] direction low: device captures bus; high: device or converter drives.
// [R05] direction is held low while idle between messages.
// [R06] request stays high until acknowledge or analog enable, then drops.
// [R07] after 500 us without answer: release bus, drop request, send fault.
// [R08] timeout starts at request rise, cancelled on acknowledge or enable.
// [R09] device decodes relative address and performs the chosen action.
// [R10] device acknowledges only after capturing or driving the data.
// [R11] device raises analog enable instead of acknowledge for analog channels.
// [R12] on analog enable, board selects channel and starts a conversion.
// [R13] for an analog address the device keeps acknowledge low.
// [R14] for a non-analog address the device keeps analog enable low.
// [R15] channel from address bits 0-2 when bank low, bits 3-5 when high.
// [R16] device keeps bank low with board mux only, high above seven.
// [R17] identity query low makes the device drive its identity code.
// [R18] identity is seven bits on lines 0-6 plus odd parity on line 7.
// [R19] reply driver enabled, active high, only while the board answers.
// [R20] reply driver disabled after answering to free the shared bus.
// [R21] besides power-up reset, activity starts only on incoming messages.
// [R22] power-on reset pulse about 75 ms long, starting about 32 ms in.
// [R23] request drops on acknowledge; device then lowers acknowledge.
module msdh_port #(
    parameter int NORESP_CYC = msdh_pkg::TIMEOUT_CYC,
    parameter int POR_DLY    = msdh_pkg::POR_DELAY_CYC,
    parameter int POR_LEN    = msdh_pkg::POR_PULSE_CYC
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // decoded messages from the command link
    input  wire logic                         msg_valid,
    input  wire logic                         msg_is_control,
    input  wire logic [msdh_pkg::ADDR_W-1:0]  msg_addr,
    input  wire logic [msdh_pkg::ARG_W-1:0]   msg_arg,
    input  wire logic [msdh_pkg::ADDR_W-1:0]  block_start,
    input  wire logic                         id_read,
    output logic                              busy,
    // device pins
    output logic [msdh_pkg::REL_W-1:0]        relative_address,
    output logic [msdh_pkg::ARG_W-1:0]        argument_bus_out,
    output logic                              argument_bus_oe,
    input  wire logic [msdh_pkg::ARG_W-1:0]   argument_bus_in,
    output logic                              transfer_dir,
    output logic                              operation_request,
    input  wire logic                         operation_done,
    input  wire logic                         analog_select_strobe,
    input  wire logic                         mux_bank_select,
    output logic                              identity_query_n,
    // on-board converter
    output logic [msdh_pkg::CH_W-1:0]         mux_channel,
    output logic                              adc_start,
    input  wire logic                         adc_done,
    input  wire logic [msdh_pkg::ARG_W-1:0]   adc_data,
    // reply uplink
    output logic                              reply_valid,
    output logic [7:0]                        reply_code,
    output logic [msdh_pkg::ARG_W-1:0]        reply_data,
    output logic                              reply_uplink_oe,
    // power-on reset pulse
    output logic                              por_reset
);
    import msdh_pkg::*;

    function automatic logic [CH_W-1:0] chan_sel(input logic [REL_W-1:0] rel,
                                                 input logic hi);
        chan_sel = hi ? rel[BANK_HI +: CH_W] : rel[BANK_LO +: CH_W];
    endfunction : chan_sel

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    localparam int SY_W = ARG_W + 3;
    logic [1:0]      rs_r;
    logic [SY_W-1:0] sy1_r, sy2_r;
    wire             rst_s_n = rs_r[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rs_r <= 2'h0;
        else        rs_r <= {rs_r[0], 1'b1};
    end
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            sy1_r <= '0;
            sy2_r <= '0;
        end else begin
            sy1_r <= {operation_done, analog_select_strobe, mux_bank_select,
                      argument_bus_in};
            sy2_r <= sy1_r;
        end
    end
    wire             done_s = sy2_r[SY_W-1];
    wire             anen_s = sy2_r[SY_W-2];
    wire             bank_s = sy2_r[SY_W-3];
    wire [ARG_W-1:0] arg_s  = sy2_r[ARG_W-1:0];

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire [ADDR_W-1:0] diff     = msg_addr - block_start;        // see [R01]
    wire              in_block = (diff[ADDR_W-1:REL_W] == '0);  // see [R01]
    msdh_state_t      st_r;
    logic [CNT_W-1:0] cnt_r;
    wire              cnt_end  = (cnt_r == '0);
    wire              go_msg   = (st_r == S_IDLE) && msg_valid
                                 && in_block;                   // see [R21]
    wire              go_id    = (st_r == S_IDLE) && !msg_valid
                                 && id_read;                    // see [R21]

    // ------------------------------------------------------------------
    // no-response timer
    // ------------------------------------------------------------------
    msdh_tmr_if tif ();
    assign tif.start  = (st_r == S_SETUP) && cnt_end;           // see [R08]
    assign tif.cancel = (st_r == S_REQ) && (done_s || anen_s);  // see [R08]
    msdh_timer #(.COUNT(NORESP_CYC)) u_tmr (
        .clk   (clk),
        .rst_n (rst_s_n),
        .t     (tif)
    );

    // ------------------------------------------------------------------
    // handshake sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            st_r              <= S_IDLE;
            cnt_r             <= '0;
            relative_address  <= '0;
            argument_bus_out  <= '0;
            argument_bus_oe   <= 1'b0;
            transfer_dir      <= 1'b0;
            operation_request <= 1'b0;
            identity_query_n  <= 1'b1;
            mux_channel       <= '0;
            adc_start         <= 1'b0;
            reply_valid       <= 1'b0;
            reply_code        <= '0;
            reply_data        <= '0;
            reply_uplink_oe   <= 1'b0;
            busy              <= 1'b0;
        end else begin
            adc_start   <= 1'b0;
            reply_valid <= 1'b0;
            unique case (st_r)
                S_IDLE: begin
                    if (go_msg) begin
                        relative_address <= diff[REL_W-1:0];    // see [R01]
                        argument_bus_out <= msg_arg;
                        argument_bus_oe  <= msg_is_control;     // see [R02]
                        transfer_dir     <= !msg_is_control;    // see [R04]
                        cnt_r            <= SETUP_CYC;
                        st_r             <= S_SETUP;
                        busy             <= 1'b1;
                    end else if (go_id) begin
                        identity_query_n <= 1'b0;               // see [R17]
                        cnt_r            <= ID_CYC;
                        st_r             <= S_IDENT;
                        busy             <= 1'b1;
                    end
                end
                S_SETUP: begin
                    cnt_r <= cnt_r - CNT_W'(1);
                    if (cnt_end) begin
                        operation_request <= 1'b1;              // see [R06]
                        st_r              <= S_REQ;
                    end
                end
                S_REQ: begin
                    if (anen_s) begin
                        operation_request <= 1'b0;              // see [R06]
                        mux_channel <= chan_sel(relative_address,
                                                bank_s);        // see [R15]
                        adc_start   <= 1'b1;                    // see [R12]
                        st_r        <= S_ADC;
                    end else if (done_s) begin
                        operation_request <= 1'b0;              // see [R23]
                        if (transfer_dir) reply_data <= arg_s;  // see [R04]
                        st_r <= S_DROP;
                    end else if (tif.expired) begin
                        operation_request <= 1'b0;              // see [R07]
                        argument_bus_oe   <= 1'b0;              // see [R07]
                        transfer_dir      <= 1'b0;              // see [R05]
                        reply_code        <= CODE_NO_RESP;      // see [R07]
                        st_r              <= S_REPLY;
                        cnt_r             <= REPLY_CYC;
                        reply_valid       <= 1'b1;
                        reply_uplink_oe   <= 1'b1;              // see [R19]
                    end
                end
                S_DROP: begin
                    if (!done_s) begin                          // see [R23]
                        argument_bus_oe <= 1'b0;                // see [R02]
                        transfer_dir    <= 1'b0;                // see [R05]
                        reply_code  <= transfer_dir ? CODE_DATA : CODE_DONE;
                        st_r            <= S_REPLY;
                        cnt_r           <= REPLY_CYC;
                        reply_valid     <= 1'b1;
                        reply_uplink_oe <= 1'b1;                // see [R19]
                    end
                end
                S_ADC: begin
                    if (adc_done) begin
                        reply_data      <= adc_data;
                        transfer_dir    <= 1'b0;                // see [R05]
                        reply_code      <= CODE_DATA;
                        st_r            <= S_REPLY;
                        cnt_r           <= REPLY_CYC;
                        reply_valid     <= 1'b1;
                        reply_uplink_oe <= 1'b1;                // see [R19]
                    end
                end
                S_IDENT: begin
                    cnt_r <= cnt_r - CNT_W'(1);
                    if (cnt_end) begin
                        reply_data       <= {{(ARG_W-ID_W){1'b0}},
                                             arg_s[ID_W-1:0]};  // see [R18]
                        identity_query_n <= 1'b1;
                        reply_code       <= CODE_ID;
                        st_r             <= S_REPLY;
                        cnt_r            <= REPLY_CYC;
                        reply_valid      <= 1'b1;
                        reply_uplink_oe  <= 1'b1;               // see [R19]
                    end
                end
                S_REPLY: begin
                    cnt_r <= cnt_r - CNT_W'(1);
                    if (cnt_r == CNT_W'(1)) begin
                        reply_uplink_oe <= 1'b0;                // see [R20]
                        st_r            <= S_IDLE;
                        busy            <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // power-on reset pulse
    // ------------------------------------------------------------------
    logic [POR_W-1:0] por_cnt_r;
    wire              por_run = (por_cnt_r != POR_W'(POR_DLY + POR_LEN));
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            por_cnt_r <= '0;
            por_reset <= 1'b0;
        end else begin
            if (por_run) por_cnt_r <= por_cnt_r + POR_W'(1);
            por_reset <= (por_cnt_r >= POR_W'(POR_DLY)) && por_run; // see [R22]
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_idle_dir_low: assert property (@(posedge clk) disable iff (!rst_s_n)
        (st_r == S_IDLE) |-> !transfer_dir && !argument_bus_oe) // see [R05]
        else $error("direction or bus drive active while idle");
    a_req_drops_ack: assert property (@(posedge clk) disable iff (!rst_s_n)
        (st_r == S_REQ && (done_s || anen_s)) |=> !operation_request) // see [R06]
        else $error("request not dropped after answer");
    a_req_holds: assert property (@(posedge clk) disable iff (!rst_s_n)
        (operation_request && !done_s && !anen_s && !tif.expired)
        |=> operation_request) // see [R06]
        else $error("request fell without an answer");
    a_timeout_fault: assert property (@(posedge clk) disable iff (!rst_s_n)
        (st_r == S_REQ && tif.expired && !done_s && !anen_s) |=>
        !operation_request && !argument_bus_oe && reply_valid
        && reply_code == CODE_NO_RESP) // see [R07]
        else $error("timeout did not raise the fault reply");
    a_mux_select: assert property (@(posedge clk) disable iff (!rst_s_n)
        adc_start |-> mux_channel == chan_sel(relative_address,
                                              $past(bank_s))) // see [R15]
        else $error("wrong multiplexer channel");
    a_reply_window: assert property (@(posedge clk) disable iff (!rst_s_n)
        $rose(reply_uplink_oe) |-> reply_valid ##1 reply_uplink_oe [*3]
        ##1 !reply_uplink_oe) // see [R20]
        else $error("reply driver window has wrong length");
    a_reply_oe_only: assert property (@(posedge clk) disable iff (!rst_s_n)
        reply_uplink_oe |-> (st_r == S_REPLY)) // see [R19]
        else $error("reply driver enabled outside a reply");
    a_bus_ctl_only: assert property (@(posedge clk) disable iff (!rst_s_n)
        argument_bus_oe |-> !transfer_dir) // see [R04]
        else $error("board drives bus during a read");
    a_rel_value: assert property (@(posedge clk) disable iff (!rst_s_n)
        go_msg |=> relative_address == $past(diff[REL_W-1:0])) // see [R01]
        else $error("relative address mismatch");
endmodule : msdh_port
`default_nettype wire

// [include/msdh_pkg.sv]
/*
 * Constants shared by the request/acknowledge port of the board logic:
 * timing figures, reply codes and counter widths.
 * Assumes a single 125 MHz clock.
 */
package msdh_pkg;
    // ------------------------------------------------------------------
    // clock and times
    // ------------------------------------------------------------------
    localparam int CLK_MHZ       = 125;
    localparam int TIMEOUT_US    = 500;
    localparam int TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;
    localparam int POR_DELAY_MS  = 32;
    localparam int POR_PULSE_MS  = 75;
    localparam int POR_DELAY_CYC = POR_DELAY_MS * CLK_MHZ * 1000;
    localparam int POR_PULSE_CYC = POR_PULSE_MS * CLK_MHZ * 1000;
    localparam int POR_W         = 24;
    localparam int TMR_W         = 20;
    // ------------------------------------------------------------------
    // widths and small counts
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 16;
    localparam int REL_W     = 8;
    localparam int ARG_W     = 16;
    localparam int CNT_W     = 8;
    localparam int CH_W      = 3;
    localparam int BANK_LO   = 0;
    localparam int BANK_HI   = 3;
    localparam int ID_W      = 8;
    localparam logic [CNT_W-1:0] SETUP_CYC = 8'h04;
    localparam logic [CNT_W-1:0] ID_CYC    = 8'h08;
    localparam logic [CNT_W-1:0] REPLY_CYC = 8'h04;
    // ------------------------------------------------------------------
    // reply codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_DONE     = 8'h01;
    localparam logic [7:0] CODE_DATA     = 8'h03;
    localparam logic [7:0] CODE_ID       = 8'h04;
    localparam logic [7:0] CODE_NO_RESP  = 8'h12;
    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_REQ, S_DROP, S_ADC, S_IDENT, S_REPLY
    } msdh_state_t;
endpackage : msdh_pkg

// [include/msdh_tmr_if.sv]
/*
 * Start/cancel/expire link between the handshake sequencer and its
 * no-response timer. Both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface msdh_tmr_if;
    logic start;
    logic cancel;
    logic expired;
    modport owner (output start, output cancel, input expired);
    modport timer (input start, input cancel, output expired);
endinterface : msdh_tmr_if
`default_nettype wire

// [rtl/msdh_timer.sv]
/*
 * One-shot down counter: loaded by start, cleared by cancel,
 * pulses expired for one cycle when the count runs out.
 * Assumes asynchronous reset whose release is already synchronised.
 */
`timescale 1ns/10ps
`default_nettype none
module msdh_timer #(
    parameter int COUNT = msdh_pkg::TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic    clk,
    input  wire logic    rst_n,
    // control
    msdh_tmr_if.timer    t
);
    import msdh_pkg::*;
    logic [TMR_W-1:0] cnt_r;
    logic             exp_r;
    wire              last = (cnt_r == TMR_W'(1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            exp_r <= 1'b0;
            if (t.cancel) begin
                cnt_r <= '0;                          // see [R08]
            end else if (t.start) begin
                cnt_r <= TMR_W'(COUNT);               // see [R08]
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - TMR_W'(1);
                exp_r <= last;                        // see [R07]
            end
        end
    end
    assign t.expired = exp_r;

    a_exp_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
        exp_r |-> $past(last) && !$past(t.cancel)) // see [R08]
        else $error("timer expired without a running count");
endmodule : msdh_timer
`default_nettype wire

// [test/msdh_dev_model.sv]
/*
 * Behavioural device logic facing the board port: address decode,
 * acknowledge or analog enable, identity drive and bus level.
 * Assumes the same clock as the board and a quiet input for silence.
 */
`timescale 1ns/10ps
`default_nettype none
module msdh_dev_model #(
    parameter logic [6:0] ID_CODE = 7'h2B  // arbitrary value
) (
    // clock and test control
    input  wire logic        clk,
    input  wire logic        quiet,
    // board pins
    input  wire logic [7:0]  rel,
    input  wire logic        dir,
    input  wire logic        req,
    input  wire logic        id_n,
    input  wire logic        adc_start,
    input  wire logic [15:0] bus_out,
    input  wire logic        bus_oe,
    output logic      [15:0] bus_lvl,
    output logic             ack,
    output logic             astrobe,
    output logic             bank,
    output logic             adc_done,
    output logic      [15:0] cmd_seen
);
    logic        analog;
    logic        drv_en;
    logic [15:0] drv_val;
    logic [15:0] float_r;
    assign analog  = rel[7];
    assign bank    = analog & rel[3];
    assign drv_en  = (req & dir & ~analog) | ~id_n;
    assign drv_val = ~id_n ? {8'h00, ~^ID_CODE, ID_CODE}
                           : {rel, ~rel};
    // undriven bus shows a pattern that flips every cycle
    assign bus_lvl = bus_oe ? bus_out
                   : drv_en ? drv_val : float_r;
    initial begin
        ack      = 1'b0;
        astrobe  = 1'b0;
        adc_done = 1'b0;
        cmd_seen = 16'h0000;
        float_r  = 16'h5A5A;
    end
    always @(posedge clk) begin
        float_r  <= ~float_r;
        adc_done <= adc_start;
        if (!req) begin
            ack     <= 1'b0;
            astrobe <= 1'b0;
        end else if (!quiet && !ack && !astrobe) begin
            if (analog) begin
                astrobe <= 1'b1;
            end else begin
                if (!dir) cmd_seen <= bus_lvl;
                ack <= 1'b1;
            end
        end
    end
endmodule : msdh_dev_model
`default_nettype wire

// [test/test_monitor_control_device_handshake.sv]
/*
 * Self-checking bench for the board port with a device model.
 * Assumes shortened timeout and power-on counts set below.
 */
`timescale 1ns/10ps
`default_nettype none
module test_monitor_control_device_handshake;
    import msdh_pkg::*;
    localparam int          NR   = 50;
    localparam int          PL   = 30;
    localparam logic [6:0]  ID   = 7'h2B;  // arbitrary value
    logic        clk, rst_n, msg_valid, msg_is_control, id_read, quiet;
    logic [15:0] msg_addr, msg_arg, adc_data, bus_lvl, bus_out, cmd_seen;
    logic [15:0] reply_data, lfsr, base;
    logic [7:0]  rel_addr, reply_code;
    logic [2:0]  mux_channel;
    logic        busy, bus_oe, dir, req, ack, astrobe, bank, id_n;
    logic        adc_start, adc_done, reply_valid, reply_oe, por;
    logic [24:0] exp_q[$];
    int          errors, check_count, req_len, por_len;
    // ------------------------------------------------------------------
    // instances
    // ------------------------------------------------------------------
    msdh_port #(.NORESP_CYC(NR), .POR_DLY(20), .POR_LEN(PL)) dut (
        .clk(clk), .rst_n(rst_n), .msg_valid(msg_valid),
        .msg_is_control(msg_is_control), .msg_addr(msg_addr),
        .msg_arg(msg_arg), .block_start(base), .id_read(id_read),
        .busy(busy), .relative_address(rel_addr), .argument_bus_out(bus_out),
        .argument_bus_oe(bus_oe), .argument_bus_in(bus_lvl),
        .transfer_dir(dir), .operation_request(req),
        .operation_done(ack), .analog_select_strobe(astrobe),
        .mux_bank_select(bank), .identity_query_n(id_n),
        .mux_channel(mux_channel), .adc_start(adc_start),
        .adc_done(adc_done), .adc_data(adc_data),
        .reply_valid(reply_valid), .reply_code(reply_code),
        .reply_data(reply_data), .reply_uplink_oe(reply_oe),
        .por_reset(por));
    msdh_dev_model #(.ID_CODE(ID)) dev (
        .clk(clk), .quiet(quiet), .rel(rel_addr), .dir(dir), .req(req),
        .id_n(id_n), .adc_start(adc_start), .bus_out(bus_out),
        .bus_oe(bus_oe), .bus_lvl(bus_lvl), .ack(ack), .astrobe(astrobe),
        .bank(bank), .adc_done(adc_done), .cmd_seen(cmd_seen));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== v && n < 400);
        if (n >= 400) chk(busy, v);
    endtask : wait_busy
    task automatic run(input logic ctl, input logic idr,
                       input logic [15:0] a, input logic [7:0] code);
        logic [7:0]  r;
        logic        an;
        logic [15:0] d;
        r  = 8'(a - base);
        an = r[7] & ~ctl & ~idr;
        d  = idr ? {8'h00, ~^ID, ID} : an ? lfsr : {r, ~r};
        exp_q.push_back({code != CODE_DATA && !idr, code, d});
        msg_is_control <= ctl;
        msg_addr       <= a;
        msg_arg        <= lfsr;
        adc_data       <= lfsr;
        if (idr) id_read <= 1'b1;
        else msg_valid <= 1'b1;
        wait_busy(1'b1);
        msg_valid <= 1'b0;
        id_read   <= 1'b0;
        wait_busy(1'b0);
        if (!idr) chk(rel_addr, r);
        if (ctl && !quiet) chk(cmd_seen, lfsr);
        if (an) chk(mux_channel, r[3] ? r[5:3] : r[2:0]);
        chk({dir, bus_oe, reply_oe, req}, 4'h0);
        lfsr = step(lfsr);
    endtask : run
    // ------------------------------------------------------------------
    // clock, monitor, counters, watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin : mon
        logic [24:0] e;
        if (req === 1'b1) req_len++;
        if (por === 1'b1) por_len++;
        if (reply_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(reply_valid, 1'b0);
            end else begin
                e = exp_q.pop_front();
                chk(reply_code, e[23:16]);
                if (!e[24]) chk(reply_data, e[15:0]);
            end
        end
    end
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n          = 1'b0;
        msg_valid      = 1'b0;
        msg_is_control = 1'b0;
        id_read        = 1'b0;
        quiet          = 1'b0;
        msg_addr       = 16'h0000;
        msg_arg        = 16'h0000;
        adc_data       = 16'h0000;
        base           = 16'h3C00;
        errors         = 0;
        check_count    = 0;
        req_len        = 0;
        por_len        = 0;
        lfsr           = 16'd31833;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(id_n, 1'b1);
        run(1'b1, 1'b0, base, CODE_DONE);
        run(1'b0, 1'b0, base + 16'h0085, CODE_DATA);
        run(1'b0, 1'b0, base + 16'h00BD, CODE_DATA);
        for (int i = 0; i < 4; i++) begin
            // move the block start so the subtraction sees varied bases
            base <= {lfsr[15:8], 8'h00};
            @(posedge clk);
            run(1'b1, 1'b0, base + (lfsr & 16'h007F), CODE_DONE);
            run(1'b0, 1'b0, base + (lfsr & 16'h007F), CODE_DATA);
            run(1'b0, 1'b0, base + 16'h0080 + (lfsr & 16'h003F),
                CODE_DATA);
        end
        quiet   <= 1'b1;
        req_len  = 0;
        run(1'b1, 1'b0, base + 16'h0010, CODE_NO_RESP);
        chk(req_len >= NR && req_len <= NR + 4, 1'b1);
        quiet   <= 1'b0;
        req_len  = 0;
        run(1'b0, 1'b0, base + 16'h007F, CODE_DATA);
        chk(req_len < 20, 1'b1);
        run(1'b0, 1'b1, 16'h0000, CODE_ID);
        msg_addr  <= base + 16'h0100;
        msg_valid <= 1'b1;
        repeat (10) @(posedge clk);
        chk(busy, 1'b0);
        msg_valid <= 1'b0;
        repeat (60) @(posedge clk);
        chk(por_len, PL);
        end_of_test();
    end
endmodule : test_monitor_control_device_handshake
`default_nettype wire
